/* File: dpc_pins.sv */
/*
  dual port pin controller: registers, pad drive, pulls, change and external interrupt
  flags, infrared carrier and alternate pin functions.
  assumes an APB master on ref_clk, pad inputs from the pins (asynchronous), alternate
  function signals from logic on ref_clk and configuration words that hold steady.
*/
`timescale 1ns/1ps
module dpc_pins (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire dpc_pkg::dpc_apb_req_s apbReq,
  output dpc_pkg::dpc_apb_rsp_s apbRsp,
  input wire logic [7:0] firstPinIn,
  input wire logic [7:0] secondPinIn,
  input wire dpc_pkg::dpc_cfg_s cfg,
  input wire dpc_pkg::dpc_alt_s altIn,
  output dpc_pkg::dpc_pad_s firstPad,
  output dpc_pkg::dpc_pad_s secondPad,
  output logic irqReq,
  output logic extResetReq,
  output logic extTimerClkA,
  output logic extTimerClkB
);
  import dpc_pkg::*;

  // whole state of the block in one word
  typedef struct packed {
    logic [7:0] firstLat;      // first port output latch
    logic [7:0] secondLat;     // second port output latch
    logic [7:0] firstDir;      // 1 = input
    logic [7:0] secondDir;     // 1 = input
    logic [7:0] firstPh;       // pull-high, bit 5 is pa5 pull-low
    logic [7:0] sharedPl;      // pull-lows of both ports
    logic [7:0] secondPh;      // second port pull-high
    logic [7:0] secondOd;      // open-drain select
    logic [7:0] chgSel;        // change detect select
    logic [7:0] irqFlag;       // sticky flags
    logic [7:0] irqEn;         // flag enables
    logic [7:0] pwrCtl;        // global enable, ext select, edge
    logic [7:0] irCtl;         // carrier enable
    logic [15:0] rdType;       // 1 = read latch
    logic [15:0] altCtl;       // alternate function enables
    logic [7:0] firstS1;       // pin synchronisers, first stage
    logic [7:0] firstS2;
    logic [7:0] secondS1;
    logic [7:0] secondS2;
    logic [7:0] secondPrev;    // previous synced sample
    logic [11:0] irCnt;        // carrier half-period counter
    logic irCar;               // carrier level
    logic [31:0] rdData;       // read data captured at setup
    logic slvErr;              // unmapped address seen at setup
    dpc_pad_s padA;            // registered pad drive
    dpc_pad_s padB;
    logic irq;
    logic extRst;
    logic tclkA;
    logic tclkB;
  } dpc_state_s;

  dpc_state_s stateFf;
  dpc_state_s nxt_state;
  logic rstSync1Ff;  // reset release synchroniser
  logic rstSyncFf;
  logic chgHit;      // any selected pin changed this cycle
  logic extHit;      // selected edge on pb0 with ext select on
  logic [7:0] chgMask;

  // reset: asserted at once, released through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1Ff <= 1'b0;
      rstSyncFf <= 1'b0;
    end else begin
      rstSync1Ff <= 1'b1;
      rstSyncFf <= rstSync1Ff;
    end
  end

  // next state of the whole block
  always_comb begin
    logic wrAcc;
    logic setup;
    logic hit;
    logic [7:0] wb;
    logic [31:0] rv;
    logic [7:0] forced;
    logic [7:0] altVal;
    logic [7:0] bVal;
    logic [7:0] bOut;
    logic [7:0] aOut;
    wrAcc = 1'b0;
    setup = 1'b0;
    hit = 1'b0;
    wb = 8'h00;
    rv = 32'h0000_0000;
    forced = 8'h00;
    altVal = 8'h00;
    bVal = 8'h00;
    bOut = 8'h00;
    aOut = 8'h00;
    nxt_state = stateFf;

    // pins pass two flops before anything reads them
    nxt_state.firstS1 = firstPinIn;
    nxt_state.firstS2 = stateFf.firstS1;
    nxt_state.secondS1 = secondPinIn;
    nxt_state.secondS2 = stateFf.secondS1;

    // change detect compares successive synced samples, every cycle
    nxt_state.secondPrev = stateFf.secondS2;
    // pb0 drops out of change detect while it serves the external interrupt
    chgMask = stateFf.chgSel & ~{7'h00, stateFf.pwrCtl[PWR_EXT_SEL_BIT]};
    chgHit = |((stateFf.secondS2 ^ stateFf.secondPrev) & chgMask);
    // edge bit 1 = falling, 0 = rising
    if (stateFf.pwrCtl[PWR_EDGE_BIT]) begin
      extHit = stateFf.secondPrev[0] & ~stateFf.secondS2[0];
    end else begin
      extHit = ~stateFf.secondPrev[0] & stateFf.secondS2[0];
    end
    extHit = extHit & stateFf.pwrCtl[PWR_EXT_SEL_BIT];

    // apb write takes effect on the access edge; zero wait states
    wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
    setup = apbReq.psel & ~apbReq.penable;
    wb = apbReq.pwdata[7:0];
    if (wrAcc) begin
      if (apbReq.paddr == OFS_FIRST_DATA) begin
        nxt_state.firstLat = wb;
      end else if (apbReq.paddr == OFS_SECOND_DATA) begin
        nxt_state.secondLat = wb;
      end else if (apbReq.paddr == OFS_FIRST_DIR) begin
        nxt_state.firstDir = wb;
      end else if (apbReq.paddr == OFS_SECOND_DIR) begin
        nxt_state.secondDir = wb;
      end else if (apbReq.paddr == OFS_FIRST_PH) begin
        nxt_state.firstPh = wb;
      end else if (apbReq.paddr == OFS_SHARED_PL) begin
        nxt_state.sharedPl = wb;
      end else if (apbReq.paddr == OFS_SECOND_PH) begin
        nxt_state.secondPh = wb;
      end else if (apbReq.paddr == OFS_SECOND_OD) begin
        nxt_state.secondOd = wb;
      end else if (apbReq.paddr == OFS_CHG_SEL) begin
        nxt_state.chgSel = wb;
      end else if (apbReq.paddr == OFS_IRQ_FLAG) begin
        // writing 0 clears a flag, writing 1 leaves it
        nxt_state.irqFlag = stateFf.irqFlag & wb;
      end else if (apbReq.paddr == OFS_IRQ_EN) begin
        nxt_state.irqEn = wb;
      end else if (apbReq.paddr == OFS_PWR_CTL) begin
        nxt_state.pwrCtl = wb;
      end else if (apbReq.paddr == OFS_IR_CTL) begin
        nxt_state.irCtl = wb;
      end else if (apbReq.paddr == OFS_RD_TYPE) begin
        nxt_state.rdType = apbReq.pwdata[15:0];
      end else if (apbReq.paddr == OFS_ALT_CTL) begin
        nxt_state.altCtl = apbReq.pwdata[15:0];
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (chgHit) begin
      nxt_state.irqFlag[FLAG_CHG_BIT] = 1'b1;
    end
    if (extHit) begin
      nxt_state.irqFlag[FLAG_EXT_BIT] = 1'b1;
    end

    // read data is captured in the setup cycle so prdata comes from a flop
    hit = 1'b1;
    if (apbReq.paddr == OFS_FIRST_DATA) begin
      rv = {24'h00_0000, (stateFf.rdType[7:0] & stateFf.firstLat) |
            (~stateFf.rdType[7:0] & stateFf.firstS2)};
    end else if (apbReq.paddr == OFS_SECOND_DATA) begin
      rv = {24'h00_0000, (stateFf.rdType[15:8] & stateFf.secondLat) |
            (~stateFf.rdType[15:8] & stateFf.secondS2)};
    end else if (apbReq.paddr == OFS_FIRST_DIR) begin
      rv = {24'h00_0000, stateFf.firstDir};
    end else if (apbReq.paddr == OFS_SECOND_DIR) begin
      rv = {24'h00_0000, stateFf.secondDir};
    end else if (apbReq.paddr == OFS_FIRST_PH) begin
      rv = {24'h00_0000, stateFf.firstPh};
    end else if (apbReq.paddr == OFS_SHARED_PL) begin
      rv = {24'h00_0000, stateFf.sharedPl};
    end else if (apbReq.paddr == OFS_SECOND_PH) begin
      rv = {24'h00_0000, stateFf.secondPh};
    end else if (apbReq.paddr == OFS_SECOND_OD) begin
      rv = {24'h00_0000, stateFf.secondOd};
    end else if (apbReq.paddr == OFS_CHG_SEL) begin
      rv = {24'h00_0000, stateFf.chgSel};
    end else if (apbReq.paddr == OFS_IRQ_FLAG) begin
      rv = {24'h00_0000, stateFf.irqFlag};
    end else if (apbReq.paddr == OFS_IRQ_EN) begin
      rv = {24'h00_0000, stateFf.irqEn};
    end else if (apbReq.paddr == OFS_PWR_CTL) begin
      rv = {24'h00_0000, stateFf.pwrCtl};
    end else if (apbReq.paddr == OFS_IR_CTL) begin
      rv = {24'h00_0000, stateFf.irCtl};
    end else if (apbReq.paddr == OFS_RD_TYPE) begin
      rv = {16'h0000, stateFf.rdType};
    end else if (apbReq.paddr == OFS_ALT_CTL) begin
      rv = {16'h0000, stateFf.altCtl};
    end else begin
      hit = 1'b0;
    end
    if (setup) begin
      nxt_state.rdData = rv;
      nxt_state.slvErr = ~hit;
    end

    // infrared carrier: free divider while enabled, parked low otherwise
    if (stateFf.irCtl[IR_EN_BIT]) begin
      if (stateFf.irCnt == IR_HALF_CYC - 12'h001) begin
        nxt_state.irCnt = 12'h000;
        nxt_state.irCar = ~stateFf.irCar;
      end else begin
        nxt_state.irCnt = stateFf.irCnt + 12'h001;
      end
    end else begin
      nxt_state.irCnt = 12'h000;
      nxt_state.irCar = 1'b0;
    end

    // second port alternate functions; routed pins become outputs on their own
    forced[6] = stateFf.altCtl[ALT_PWM1_BIT] | stateFf.altCtl[ALT_CMP_BIT];
    forced[7] = stateFf.altCtl[ALT_BZ1_BIT];
    forced[4] = stateFf.altCtl[ALT_PWM2_BIT];
    forced[5] = stateFf.altCtl[ALT_BZ2_BIT];
    forced[1] = stateFf.irCtl[IR_EN_BIT];
    // comparator takes pb6 ahead of pwm one
    altVal[6] = stateFf.altCtl[ALT_CMP_BIT] ? altIn.cmpOut : altIn.pwmOne;
    altVal[7] = altIn.buzzerOne;
    altVal[4] = altIn.pwmTwo;
    altVal[5] = altIn.buzzerTwo;
    altVal[1] = stateFf.irCar;
    bVal = (forced & altVal) | (~forced & stateFf.secondLat);
    bOut = ~stateFf.secondDir | forced;
    nxt_state.padB.dout = bVal;
    // open-drain pins only ever pull low
    nxt_state.padB.oe = bOut & ~(stateFf.secondOd & bVal);
    nxt_state.padB.pullHi = stateFf.secondPh & ~bOut;
    // pb7..pb4 carry no pull-low
    nxt_state.padB.pullLo = {4'h0, stateFf.sharedPl[7:4]} & ~bOut;
    nxt_state.padB.strongPull = cfg.secondPortPullStrength;

    // first port: pa5 open-drain always, no open-drain elsewhere
    aOut = ~stateFf.firstDir;
    nxt_state.padA.dout = stateFf.firstLat;
    nxt_state.padA.oe = aOut & ~{2'b00, stateFf.firstLat[5], 5'b0_0000};
    nxt_state.padA.pullHi = stateFf.firstPh & FIRST_PH_MASK & ~aOut;
    nxt_state.padA.pullLo = {2'b00, stateFf.firstPh[5], 1'b0, stateFf.sharedPl[3:0]} & ~aOut;
    nxt_state.padA.strongPull = cfg.firstPortPullStrength;
    if (cfg.resetPinEnable) begin
      // pa5 is a pure reset input then
      nxt_state.padA.oe[5] = 1'b0;
      nxt_state.padA.dout[5] = 1'b0;
    end
    if (cfg.crystalModeEnable) begin
      // crystal owns pa7/pa6: no drive, no pulls
      nxt_state.padA.oe[7:6] = 2'b00;
      nxt_state.padA.dout[7:6] = 2'b00;
      nxt_state.padA.pullHi[7:6] = 2'b00;
    end else if (cfg.instrClkOutEnable) begin
      nxt_state.padA.oe[7] = 1'b1;
      nxt_state.padA.dout[7] = altIn.instrClk;
      nxt_state.padA.pullHi[7] = 1'b0;
    end

    // side signals; the reset pin level is read only after synchronising
    nxt_state.extRst = cfg.resetPinEnable & ~stateFf.firstS2[5];
    nxt_state.tclkA = stateFf.firstS2[4] &
      ((stateFf.altCtl[ALT_T0SRC_BIT] & ~stateFf.altCtl[ALT_T0LOW_BIT]) |
       stateFf.altCtl[ALT_T1SRC_BIT]);
    nxt_state.tclkB = stateFf.secondS2[3] & stateFf.altCtl[ALT_T2SRC_BIT];
    nxt_state.irq = stateFf.pwrCtl[PWR_GLOBAL_BIT] &
      |(stateFf.irqFlag & stateFf.irqEn & 8'h06);
  end

  // one register stage for the whole block
  always_ff @(posedge ref_clk or negedge rstSyncFf) begin
    if (!rstSyncFf) begin
      stateFf <= '0;
      stateFf.firstDir <= RST_DIR;
      stateFf.secondDir <= RST_DIR;
      stateFf.pwrCtl <= RST_BYTE;
    end else begin
      stateFf <= nxt_state;
    end
  end

  // outputs
  assign apbRsp.prdata = stateFf.rdData;
  assign apbRsp.pready = apbReq.psel & apbReq.penable;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & stateFf.slvErr;
  assign firstPad = stateFf.padA;
  assign secondPad = stateFf.padB;
  assign irqReq = stateFf.irq;
  assign extResetReq = stateFf.extRst;
  assign extTimerClkA = stateFf.tclkA;
  assign extTimerClkB = stateFf.tclkB;

  // a selected change reaches the flag one edge later
  AST_CHG_SETS_FLAG: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    chgHit |=> stateFf.irqFlag[FLAG_CHG_BIT])
    else $error("change did not set flag");

  // pb0 alone changing under ext select must not raise the change flag
  AST_EXT_PRIORITY: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    stateFf.pwrCtl[PWR_EXT_SEL_BIT] && !stateFf.irqFlag[FLAG_CHG_BIT] &&
    ((stateFf.secondS2 ^ stateFf.secondPrev) == 8'h01) |=> !stateFf.irqFlag[FLAG_CHG_BIT])
    else $error("pb0 change flagged while ext select set");

  // interrupt request needs flag, enable and global enable, one edge apart
  AST_IRQ_GATING: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    irqReq |-> $past(stateFf.pwrCtl[PWR_GLOBAL_BIT]) && ($past(stateFf.irqFlag & stateFf.irqEn) & 8'h06) != 8'h00)
    else $error("irq without flag and enables");

  // carrier toggles exactly at the half-period count
  AST_IR_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    stateFf.irCtl[IR_EN_BIT] && $past(stateFf.irCtl[IR_EN_BIT]) && stateFf.irCnt == 12'h000 &&
    $past(stateFf.irCnt) == IR_HALF_CYC - 12'h001 |-> stateFf.irCar != $past(stateFf.irCar))
    else $error("carrier missed its toggle");

  // pa5 never drives high
  AST_PA5_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    firstPad.oe[5] |-> !firstPad.dout[5])
    else $error("pa5 driven high");

  // no pull-high while a second port pin drives
  AST_PULL_ONLY_INPUT: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    (secondPad.pullHi & secondPad.oe) == 8'h00)
    else $error("pull-high on driving pin");

  // routed buzzer one drives pb7 push-pull after one edge
  AST_FORCED_OUTPUT: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    stateFf.altCtl[ALT_BZ1_BIT] && !stateFf.secondOd[7] |=> secondPad.oe[7])
    else $error("buzzer pin not forced to output");

  // timer two clock follows synced pb3 one edge later
  AST_TIMER_B_CLK: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    stateFf.altCtl[ALT_T2SRC_BIT] |=> extTimerClkB == $past(stateFf.secondS2[3]))
    else $error("timer two clock wrong");

  // a low reset pin with the option on asks for reset
  AST_RESET_PIN: assert property (@(posedge ref_clk) disable iff (!rstSyncFf)
    cfg.resetPinEnable && !stateFf.firstS2[5] |=> extResetReq)
    else $error("reset pin ignored");
endmodule : dpc_pins

/* File: dpc_pkg.sv */
/*
  constants, register map and bus, pad and pin types for the dual port pin controller.
  assumes a 200 MHz ref_clk, an APB master with 32-bit data and static configuration-word inputs.
*/
package dpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FIRST_DATA = 8'h00;
  localparam logic [7:0] OFS_SECOND_DATA = 8'h04;
  localparam logic [7:0] OFS_FIRST_DIR = 8'h08;
  localparam logic [7:0] OFS_SECOND_DIR = 8'h0c;
  localparam logic [7:0] OFS_FIRST_PH = 8'h10;
  localparam logic [7:0] OFS_SHARED_PL = 8'h14;
  localparam logic [7:0] OFS_SECOND_PH = 8'h18;
  localparam logic [7:0] OFS_SECOND_OD = 8'h1c;
  localparam logic [7:0] OFS_CHG_SEL = 8'h20;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] OFS_PWR_CTL = 8'h2c;
  localparam logic [7:0] OFS_IR_CTL = 8'h30;
  localparam logic [7:0] OFS_RD_TYPE = 8'h34;
  localparam logic [7:0] OFS_ALT_CTL = 8'h38;
  // field positions
  localparam int FLAG_CHG_BIT = 1;
  localparam int FLAG_EXT_BIT = 2;
  localparam int PWR_GLOBAL_BIT = 7;
  localparam int PWR_EXT_SEL_BIT = 6;
  localparam int PWR_EDGE_BIT = 0;
  localparam int IR_EN_BIT = 0;
  localparam int ALT_PWM1_BIT = 0;
  localparam int ALT_BZ1_BIT = 1;
  localparam int ALT_PWM2_BIT = 2;
  localparam int ALT_BZ2_BIT = 3;
  localparam int ALT_CMP_BIT = 4;
  localparam int ALT_T0SRC_BIT = 8;
  localparam int ALT_T0LOW_BIT = 9;
  localparam int ALT_T1SRC_BIT = 10;
  localparam int ALT_T2SRC_BIT = 11;
  // reset values: all pins start as inputs
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // first port feature masks
  localparam logic [7:0] FIRST_PH_MASK = 8'hdf;
  // infrared carrier timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint IR_CARRIER_HZ = 38_000;
  localparam logic [11:0] IR_HALF_CYC = 12'(CLK_HZ / (2 * IR_CARRIER_HZ));

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dpc_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dpc_apb_rsp_s;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pullHi;
    logic [7:0] pullLo;
    logic strongPull;
  } dpc_pad_s;
  typedef struct packed {
    logic resetPinEnable;
    logic crystalModeEnable;
    logic instrClkOutEnable;
    logic firstPortPullStrength;
    logic secondPortPullStrength;
  } dpc_cfg_s;
  typedef struct packed {
    logic pwmOne;
    logic buzzerOne;
    logic pwmTwo;
    logic buzzerTwo;
    logic cmpOut;
    logic instrClk;
  } dpc_alt_s;
endpackage : dpc_pkg

/* File: dpc_board.sv */
/*
  board model: turns the controller's pad drive, the pulls and the bench's own
  pin drivers into the levels seen at the pins.
  assumes pad structs from the pin controller; the bench sets extEn and extVal.
*/
`timescale 1ns/1ps
module dpc_board (
  input wire logic ref_clk,
  input wire dpc_pkg::dpc_pad_s firstPad,
  input wire dpc_pkg::dpc_pad_s secondPad,
  input wire logic [15:0] extEn,
  input wire logic [15:0] extVal,
  output logic [7:0] firstPinIn,
  output logic [7:0] secondPinIn
);
  import dpc_pkg::*;
  logic fltToggle = 1'b0; // a floating pin reads a changing level, never a stale one
  // toggle each cycle so no undriven pin can pass as a steady value
  always @(posedge ref_clk) begin
    fltToggle <= ~fltToggle;
  end
  // own drive first, then board drivers, then pulls, else floating
  function automatic logic [7:0] resolve(input dpc_pad_s pad, input logic [7:0] en, input logic [7:0] val,
                                         input logic flt);
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) begin
        resolve[i] = pad.dout[i];
      end else if (en[i]) begin
        resolve[i] = val[i];
      end else if (pad.pullHi[i]) begin
        resolve[i] = 1'b1;
      end else if (pad.pullLo[i]) begin
        resolve[i] = 1'b0;
      end else begin
        resolve[i] = flt;
      end
    end
  endfunction : resolve
  assign firstPinIn = resolve(firstPad, extEn[7:0], extVal[7:0], fltToggle);
  assign secondPinIn = resolve(secondPad, extEn[15:8], extVal[15:8], ~fltToggle);
endmodule : dpc_board

/* File: test_dual_port_pin_control.sv */
/*
  self-checking bench for the dual port pin controller: apb tasks and scenarios.
  assumes dpc_pkg, dpc_pins and dpc_board compiled first; 200 MHz ref_clk.
*/
`timescale 1ns/1ps
module test_dual_port_pin_control;
  import dpc_pkg::*;
  logic ref_clk;
  logic nrst;
  dpc_apb_req_s req;
  dpc_apb_rsp_s rsp;
  dpc_cfg_s cfg;
  dpc_alt_s altIn;
  dpc_pad_s firstPad;
  dpc_pad_s secondPad;
  logic [7:0] firstPinIn;
  logic [7:0] secondPinIn;
  logic [15:0] extEn; // board drivers, bits 15:8 serve the second port
  logic [15:0] extVal;
  logic irqReq;
  logic extResetReq;
  logic extTimerClkA;
  logic extTimerClkB;
  logic [31:0] rdData;
  logic rdErr;
  logic prevLvl;
  int numErrors;
  int nCompared;
  int k;
  int n;
  int lastI;

  dpc_pins u_dpc_pins (.ref_clk(ref_clk), .nrst(nrst), .apbReq(req), .apbRsp(rsp), .firstPinIn(firstPinIn),
    .secondPinIn(secondPinIn), .cfg(cfg), .altIn(altIn), .firstPad(firstPad), .secondPad(secondPad),
    .irqReq(irqReq), .extResetReq(extResetReq), .extTimerClkA(extTimerClkA), .extTimerClkB(extTimerClkB));
  dpc_board u_dpc_board (.ref_clk(ref_clk), .firstPad(firstPad), .secondPad(secondPad), .extEn(extEn),
    .extVal(extVal), .firstPinIn(firstPinIn), .secondPinIn(secondPinIn));

  // free-running 5 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // single exit point of the run
  task automatic stop_test;
    $display("errors %0d compares %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // one apb transfer; an idle edge first so no signal is assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int w;
    @(posedge ref_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wd;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (rsp.pready !== 1'b1 && w < 20);
    if (w >= 20) begin
      numErrors++;
      stop_test();
    end
    rdData = rsp.prdata;
    rdErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : cyc

  // toggle one second-port pin and let the sync chain settle
  task automatic flipB(input int b);
    extVal[8+b] <= ~extVal[8+b];
    cyc(8);
  endtask : flipB

  // main sequence
  initial begin
    req = '0;
    nrst = 1'b0;
    // reset pin option off at first, so the pa5 open-drain drive is visible
    cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    altIn = '0;
    extEn = 16'hffff;
    extVal = 16'hffff;
    numErrors = 0;
    nCompared = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(3);
    apb(1'b0, OFS_FIRST_DIR, 0);
    chk(rdData, 8'hff, "dir a reset");
    apb(1'b0, OFS_SECOND_DIR, 0);
    chk(rdData, 8'hff, "dir b reset");
    apb(1'b0, 8'h3c, 0);
    chk(rdErr, 1'b1, "unmapped err");
    chk({firstPad.strongPull, secondPad.strongPull}, 2'b10, "strength");
    // first port as outputs; pin five only ever pulls low
    apb(1'b1, OFS_FIRST_DIR, 0);
    apb(1'b1, OFS_FIRST_DATA, 8'h5a);
    cyc(2);
    chk(firstPad.dout, 8'h5a, "dout a");
    chk(firstPad.oe, 8'hff, "oe a");
    apb(1'b1, OFS_FIRST_DATA, 8'h20);
    cyc(2);
    chk(firstPad.oe[5], 1'b0, "pa5 opendrain");
    apb(1'b1, OFS_FIRST_DIR, 8'hff);
    // pin level versus latch on read
    extVal[15:8] <= 8'h3c;
    apb(1'b1, OFS_SECOND_DATA, 8'hc3);
    cyc(4);
    apb(1'b0, OFS_SECOND_DATA, 0);
    chk(rdData, 8'h3c, "read pin");
    apb(1'b1, OFS_RD_TYPE, 16'hff00);
    apb(1'b0, OFS_SECOND_DATA, 0);
    chk(rdData, 8'hc3, "read latch");
    apb(1'b1, OFS_RD_TYPE, 0);
    // pulls on inputs
    apb(1'b1, OFS_FIRST_PH, 8'hff);
    apb(1'b1, OFS_SHARED_PL, 8'hff);
    apb(1'b1, OFS_SECOND_PH, 8'hff);
    cyc(2);
    chk(firstPad.pullHi, 8'hdf, "pullhi a");
    chk(firstPad.pullLo, 8'h2f, "pulllo a");
    chk(secondPad.pullHi, 8'hff, "pullhi b");
    chk(secondPad.pullLo, 8'h0f, "pulllo b");
    // open drain on second port outputs
    apb(1'b1, OFS_SECOND_DIR, 0);
    apb(1'b1, OFS_SECOND_OD, 8'hff);
    apb(1'b1, OFS_SECOND_DATA, 8'hf0);
    cyc(2);
    chk(secondPad.oe, 8'h0f, "od oe");
    chk(secondPad.pullHi, 8'h00, "no pull out");
    apb(1'b1, OFS_SECOND_OD, 0);
    cyc(2);
    chk(secondPad.oe, 8'hff, "pushpull oe");
    apb(1'b1, OFS_SECOND_DIR, 8'hff);
    // change flag and its interrupt
    apb(1'b1, OFS_CHG_SEL, 8'hff);
    apb(1'b1, OFS_IRQ_EN, 8'h02);
    apb(1'b1, OFS_PWR_CTL, 8'h80);
    cyc(4);
    apb(1'b1, OFS_IRQ_FLAG, 0);
    // the request must drop first, or the wait below sees the old one
    cyc(2);
    chk(irqReq, 1'b0, "irq cleared");
    extVal[10] <= ~extVal[10];
    for (k = 0; k < 10 && irqReq !== 1'b1; k++) @(posedge ref_clk);
    chk(irqReq, 1'b1, "irq");
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[1], 1'b1, "flag");
    apb(1'b1, OFS_IRQ_FLAG, 0);
    apb(1'b1, OFS_PWR_CTL, 0);
    cyc(2);
    chk(irqReq, 1'b0, "irq clear");
    flipB(2);
    chk(irqReq, 1'b0, "irq masked");
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[1], 1'b1, "flag masked");
    apb(1'b1, OFS_PWR_CTL, 8'h40);
    cyc(4);
    apb(1'b1, OFS_IRQ_FLAG, 0);
    flipB(0);
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[2:1], 2'b10, "pb0 excluded");
    flipB(1);
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[1], 1'b1, "pb1 kept");
    // falling edge select: pb0 now goes low, then high again
    apb(1'b1, OFS_PWR_CTL, 8'h41);
    apb(1'b1, OFS_IRQ_FLAG, 0);
    flipB(0);
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[2:1], 2'b10, "ext falling");
    apb(1'b1, OFS_IRQ_FLAG, 0);
    flipB(0);
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[2:1], 2'b00, "ext rise ignored");
    apb(1'b1, OFS_CHG_SEL, 0);
    apb(1'b1, OFS_PWR_CTL, 0);
    apb(1'b1, OFS_IRQ_FLAG, 0);
    // an unselected pin must not flag
    flipB(3);
    apb(1'b0, OFS_IRQ_FLAG, 0);
    chk(rdData[2:1], 2'b00, "unselected pin");
    // infrared carrier half period
    apb(1'b1, OFS_SECOND_DIR, 8'hfd);
    apb(1'b1, OFS_IR_CTL, 1);
    prevLvl = secondPad.dout[1];
    n = 0;
    lastI = 0;
    for (k = 0; k < 8000; k++) begin
      @(posedge ref_clk);
      if (secondPad.dout[1] !== prevLvl) begin
        prevLvl = secondPad.dout[1];
        n++;
        if (n == 3) chk(k - lastI, IR_HALF_CYC, "ir half");
        lastI = k;
      end
    end
    chk(n >= 3, 1'b1, "ir toggles");
    apb(1'b1, OFS_IR_CTL, 0);
    apb(1'b1, OFS_SECOND_DIR, 8'hff);
    // reset pin, with the option now switched on
    cfg.resetPinEnable <= 1'b1;
    extVal[5] <= 1'b0;
    for (k = 0; k < 8 && extResetReq !== 1'b1; k++) @(posedge ref_clk);
    chk(extResetReq, 1'b1, "reset pin");
    extVal[5] <= 1'b1;
    cyc(6);
    chk(extResetReq, 1'b0, "reset pin off");
    // instruction clock on pa7, then the crystal takes pa7 and pa6 back
    cfg.instrClkOutEnable <= 1'b1;
    altIn.instrClk <= 1'b1;
    cyc(2);
    chk({firstPad.oe[7], firstPad.dout[7], firstPad.pullHi[7]}, 3'b110, "instr clk out");
    cfg.crystalModeEnable <= 1'b1;
    cyc(2);
    chk({firstPad.oe[7:6], firstPad.pullHi[7:6]}, 4'h0, "crystal pins");
    // timer clock inputs
    apb(1'b1, OFS_ALT_CTL, 16'h0900);
    extVal[4] <= 1'b0;
    extVal[11] <= 1'b0;
    cyc(5);
    chk({extTimerClkA, extTimerClkB}, 2'b00, "tclk low");
    extVal[4] <= 1'b1;
    extVal[11] <= 1'b1;
    cyc(5);
    chk({extTimerClkA, extTimerClkB}, 2'b11, "tclk high");
    apb(1'b1, OFS_ALT_CTL, 16'h0300);
    cyc(4);
    chk(extTimerClkA, 1'b0, "tclk lowosc");
    apb(1'b1, OFS_ALT_CTL, 16'h0600);
    cyc(4);
    chk(extTimerClkA, 1'b1, "tclk timer one");
    // alternate outputs force direction; comparator beats pwm one
    altIn.pwmOne <= 1'b1;
    altIn.pwmTwo <= 1'b1;
    apb(1'b1, OFS_ALT_CTL, 16'h000f);
    cyc(3);
    chk(secondPad.oe[7:4], 4'hf, "alt oe");
    chk(secondPad.dout[7:4], 4'h5, "alt dout");
    apb(1'b1, OFS_ALT_CTL, 16'h001f);
    cyc(3);
    chk(secondPad.dout[6], 1'b0, "cmp wins");
    stop_test();
  end
endmodule : test_dual_port_pin_control
